//--- common/branch_sysctl_pkg.sv
`default_nettype none
package branch_sysctl_pkg;

  // ************************************************************
  // instruction word layout
  // ************************************************************
  localparam logic [3:0]  OP_SYS      = 4'h0;
  localparam logic [3:0]  OP_FLG_IMM  = 4'h1;
  localparam logic [3:0]  OP_FLG_AND  = 4'h2;
  localparam logic [3:0]  OP_FLG_OR   = 4'h3;
  localparam logic [3:0]  OP_FLG_XOR  = 4'h4;
  localparam logic [3:0]  OP_FLG_LDM  = 4'h5;
  localparam logic [3:0]  OP_FLG_STM  = 4'h6;
  localparam logic [3:0]  OP_BCC8     = 4'h7;
  localparam logic [3:0]  OP_BCC16    = 4'h8;
  localparam logic [3:0]  OP_GO_ABS   = 4'h9;
  localparam logic [3:0]  OP_CALL32   = 4'hA;
  localparam logic [3:0]  OP_CALL8    = 4'hB;
  localparam logic [3:0]  OP_CALL16   = 4'hC;
  localparam logic [3:0]  OP_GO_IND   = 4'hD;
  localparam logic [3:0]  OP_FLG_LDR  = 4'hE;
  localparam logic [3:0]  OP_FLG_STR  = 4'hF;
  // second operation field of OP_SYS, bits 11:8
  localparam logic [3:0]  SUB_IDLE    = 4'h0;
  localparam logic [3:0]  SUB_SLEEP   = 4'h1;
  localparam logic [3:0]  SUB_RTS     = 4'h2;
  localparam logic [3:0]  SUB_XRET    = 4'h3;
  localparam logic [3:0]  SUB_TRAP    = 4'h4;
  localparam logic [3:0]  SUB_MVB     = 4'h5;
  localparam logic [3:0]  SUB_MVW     = 4'h6;
  // condition field bits 11:9 pick the pair, bit 8 inverts
  localparam logic [2:0]  CC_ALWAYS   = 3'h0;
  localparam logic [2:0]  CC_HIGHER   = 3'h1;
  localparam logic [2:0]  CC_CARRY    = 3'h2;
  localparam logic [2:0]  CC_ZERO     = 3'h3;
  localparam logic [2:0]  CC_OVF      = 3'h4;
  localparam logic [2:0]  CC_SIGN     = 3'h5;
  localparam logic [2:0]  CC_GE       = 3'h6;
  localparam logic [2:0]  CC_GT       = 3'h7;

  // ************************************************************
  // flags, registers, constants
  // ************************************************************
  localparam int          FLG_C       = 0;
  localparam int          FLG_V       = 1;
  localparam int          FLG_Z       = 2;
  localparam int          FLG_N       = 3;
  localparam logic [7:0]  FLAGS_RST   = 8'h80;
  localparam logic [23:0] PC_RST      = 24'h000000;
  localparam logic [23:0] INSN_BYTES  = 24'h000002;
  localparam logic [15:0] WORD_STEP   = 16'h0002;
  localparam logic [31:0] STACK_STEP  = 32'h00000004;
  localparam logic [31:0] PTR_STEP    = 32'h00000001;
  localparam logic [15:0] VEC_BASE    = 16'h0020;
  localparam logic [2:0]  CNT_REG     = 3'h4;
  localparam logic [2:0]  SRC_REG     = 3'h5;
  localparam logic [2:0]  DST_REG     = 3'h6;
  localparam logic [2:0]  SP_REG      = 3'h7;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0]  A_CTRL      = 8'h00;
  localparam logic [7:0]  A_STAT      = 8'h04;
  localparam logic [7:0]  A_PC        = 8'h08;
  localparam logic [7:0]  A_FLAGS     = 8'h0C;
  localparam logic [2:0]  ER_PAGE     = 3'h1;
  localparam int          CTRL_GO     = 0;
  localparam int          STAT_HALT   = 0;
  localparam int          STAT_SLEEP  = 1;
  localparam int          STAT_EXTERR = 2;
  localparam int          STAT_BADOP  = 3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ************************************************************
  // carriers and state
  // ************************************************************
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        ready;
    logic [15:0] rdata;
  } mem_rsp_t;

  typedef enum logic [3:0] {
    S_HALT, S_FETCH, S_DECODE, S_EXT, S_EXEC, S_LDM, S_STM,
    S_PUSH_HI, S_PUSH_LO, S_RD_HI, S_RD_LO, S_MV_RD, S_MV_WR, S_SLEEP
  } cpu_state_t;

  typedef struct packed {
    cpu_state_t       st;
    logic [23:0]      pc;
    logic [7:0]       flg;
    logic [7:0][31:0] er;
    logic [15:0]      ir;
    logic [31:0]      ext;
    logic [1:0]       ext_left;
    logic [23:0]      tgt;
    logic [15:0]      addr;
    logic [15:0]      hi;
    logic [7:0]       mv_byte;
    logic             ext_err;
    logic             bad_op;
    logic             aw_got;
    logic [7:0]       awaddr;
    logic             w_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } core_t;

endpackage : branch_sysctl_pkg
`default_nettype wire

//--- hw/branch_sysctl_block_move_decode.sv
// Functional notes
// - conditional branch taken on simple carry, zero, overflow, negative tests; always/never.
// - compound tests: higher, lower-or-same, greater-equal, less-than, greater, less-equal.
// - jump loads the target into the program counter with no flag test.
// - relative and absolute subroutine calls save a return point and transfer control.
// - subroutine return resumes at the return point of the latest call.
// - software trap starts exception handling instead of finishing normally.
// - exception return restores the saved flags and program counter.
// - sleep enters power-down and stops fetching.
// - flags load copies the source byte; memory source read by word access.
// - flags store copies the flags out; memory destination written by word access.
// - immediate and, or, xor combine the flags with an instruction byte.
// - no-operation only advances the program counter by two.
// - block move skips at count zero, else copies bytes, bumps pointers, counts down.
// - byte variant counts with the low count byte, word variant with the count word.
// - the next instruction starts right after the last block-move byte.
// - instruction code is fetched and consumed in 16-bit words.
// - the leading four bits always belong to the operation field.
// - words may hold two operation fields, two register fields or none.
// - address registers use 3-bit codes; data registers 3-bit or 4-bit codes.
// - extensions carry 8, 16 or 32 bits of immediate, address or displacement.
// - a 24-bit address travels as 32 bits whose top byte is zero.
// - conditional branches carry a condition field choosing the test.
`timescale 1ns/10ps
`default_nettype none
module branch_sysctl_block_move_decode
  import branch_sysctl_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      arst_n,
  input  wire axil_req_t axi_req,
  output var  axil_rsp_t axi_rsp,
  output var  mem_req_t  mem_req,
  input  wire mem_rsp_t  mem_rsp,
  output var  logic      power_down
);

  // ************************************************************
  // reset release and state
  // ************************************************************
  logic [1:0]  rst_sync_r;
  logic        rst_n;
  core_t       core_r;
  core_t       core_nxt;
  logic        halted;
  logic [3:0]  op;
  logic [3:0]  sub;
  logic        is_trap;
  logic        mvw;
  logic [15:0] cnt;
  logic [31:0] sp_m4;
  logic [23:0] rel8;
  logic [23:0] rel16;
  logic        taken;
  logic [7:0]  wa;
  logic [7:0]  ra;
  logic [1:0]  ext_need;

  // release is synchronised so all state leaves reset on one edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
    logic base;
    base = 1'b1;
    unique case (cc[3:1])
      CC_ALWAYS: base = 1'b1;
      CC_HIGHER: base = !(f[FLG_C] | f[FLG_Z]);
      CC_CARRY:  base = !f[FLG_C];
      CC_ZERO:   base = !f[FLG_Z];
      CC_OVF:    base = !f[FLG_V];
      CC_SIGN:   base = !f[FLG_N];
      CC_GE:     base = !(f[FLG_N] ^ f[FLG_V]);
      CC_GT:     base = !(f[FLG_Z] | (f[FLG_N] ^ f[FLG_V]));
    endcase
    // odd codes are the inverse test of the even code below them
    return base ^ cc[0];
  endfunction : cond_true

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) v[8*i +: 8] = wd[8*i +: 8];
    end
    return v;
  endfunction : merge

  // ************************************************************
  // decode signals
  // ************************************************************
  // op field leads
  assign op      = core_r.ir[15:12];
  assign sub     = core_r.ir[11:8];
  assign is_trap = (op == OP_SYS) && (sub == SUB_TRAP);
  assign halted  = (core_r.st == S_HALT) || (core_r.st == S_SLEEP);
  assign mvw     = (sub == SUB_MVW);
  assign cnt     = mvw ? core_r.er[CNT_REG][15:0] : {8'h00, core_r.er[CNT_REG][7:0]};
  assign sp_m4   = core_r.er[SP_REG] - STACK_STEP;
  assign rel8    = core_r.pc + {{16{core_r.ir[7]}}, core_r.ir[7:0]};
  assign rel16   = core_r.pc + {{8{core_r.ext[15]}}, core_r.ext[15:0]};
  assign taken   = cond_true(core_r.ir[11:8], core_r.flg);
  assign wa      = {core_r.awaddr[7:2], 2'b00};
  assign ra      = {axi_req.araddr[7:2], 2'b00};
  assign power_down = (core_r.st == S_SLEEP);

  // extension words that follow the first instruction word
  always_comb begin
    ext_need = 2'd0;
    if (op == OP_BCC16 || op == OP_CALL16) ext_need = 2'd1;
    if (op == OP_GO_ABS || op == OP_CALL32) ext_need = 2'd2;
  end

  // bus answers come straight from the held flags
  assign axi_rsp.awready = !core_r.aw_got && !core_r.bvalid;
  assign axi_rsp.wready  = !core_r.w_got && !core_r.bvalid;
  assign axi_rsp.bvalid  = core_r.bvalid;
  assign axi_rsp.bresp   = core_r.bresp;
  assign axi_rsp.arready = !core_r.rvalid;
  assign axi_rsp.rvalid  = core_r.rvalid;
  assign axi_rsp.rdata   = core_r.rdata;
  assign axi_rsp.rresp   = core_r.rresp;

  // ************************************************************
  // memory requests
  // ************************************************************
  // word accesses; block-move reads and writes go by byte
  always_comb begin
    mem_req = '0;
    unique case (core_r.st)
      S_FETCH, S_EXT: begin
        mem_req.valid = 1'b1;
        mem_req.word  = 1'b1;
        mem_req.addr  = core_r.pc[15:0];
      end
      S_LDM, S_RD_HI: begin
        mem_req.valid = 1'b1;
        mem_req.word  = 1'b1;
        mem_req.addr  = core_r.addr;
      end
      S_RD_LO: begin
        mem_req.valid = 1'b1;
        mem_req.word  = 1'b1;
        mem_req.addr  = core_r.addr + WORD_STEP;
      end
      S_STM: begin
        mem_req.valid = 1'b1;
        mem_req.write = 1'b1;
        mem_req.word  = 1'b1;
        mem_req.addr  = core_r.addr;
        mem_req.wdata = {core_r.flg, 8'h00};
      end
      S_PUSH_HI: begin
        mem_req.valid = 1'b1;
        mem_req.write = 1'b1;
        mem_req.word  = 1'b1;
        mem_req.addr  = sp_m4[15:0];
        mem_req.wdata = core_r.hi;
      end
      S_PUSH_LO: begin
        mem_req.valid = 1'b1;
        mem_req.write = 1'b1;
        mem_req.word  = 1'b1;
        mem_req.addr  = sp_m4[15:0] + WORD_STEP;
        mem_req.wdata = core_r.pc[15:0];
      end
      S_MV_RD: begin
        mem_req.valid = 1'b1;
        mem_req.addr  = core_r.er[SRC_REG][15:0];
      end
      S_MV_WR: begin
        mem_req.valid = 1'b1;
        mem_req.write = 1'b1;
        mem_req.addr  = core_r.er[DST_REG][15:0];
        mem_req.wdata = {8'h00, core_r.mv_byte};
      end
      default: mem_req = '0;
    endcase
  end

  // ************************************************************
  // next state: register bus first, core second
  // ************************************************************
  always_comb begin
    core_nxt = core_r;
    // write address and data are taken in either order
    if (axi_req.awvalid && axi_rsp.awready) begin
      core_nxt.aw_got = 1'b1;
      core_nxt.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      core_nxt.w_got = 1'b1;
      core_nxt.wdata = axi_req.wdata;
      core_nxt.wstrb = axi_req.wstrb;
    end
    if (core_r.bvalid && axi_req.bready) core_nxt.bvalid = 1'b0;
    // software may touch pc, flags and registers only while the core is stopped; status bits clear any time
    if (core_r.aw_got && core_r.w_got) begin
      core_nxt.aw_got = 1'b0;
      core_nxt.w_got  = 1'b0;
      core_nxt.bvalid = 1'b1;
      core_nxt.bresp  = RESP_OKAY;
      if (wa == A_CTRL) begin
        if (core_r.wstrb[0] && core_r.wdata[CTRL_GO] && halted) core_nxt.st = S_FETCH;
      end else if (wa == A_STAT) begin
        if (core_r.wstrb[0] && core_r.wdata[STAT_EXTERR]) core_nxt.ext_err = 1'b0;
        if (core_r.wstrb[0] && core_r.wdata[STAT_BADOP]) core_nxt.bad_op = 1'b0;
      end else if (!halted) begin
        core_nxt.bresp = RESP_SLVERR;
      end else if (wa == A_PC) begin
        core_nxt.pc = 24'(merge({8'h00, core_r.pc}, core_r.wdata, core_r.wstrb));
      end else if (wa == A_FLAGS) begin
        core_nxt.flg = 8'(merge({24'h0, core_r.flg}, core_r.wdata, core_r.wstrb));
      end else if (wa[7:5] == ER_PAGE) begin
        core_nxt.er[wa[4:2]] = merge(core_r.er[wa[4:2]], core_r.wdata, core_r.wstrb);
      end else begin
        core_nxt.bresp = RESP_SLVERR;
      end
    end
    if (core_r.rvalid && axi_req.rready) core_nxt.rvalid = 1'b0;
    if (axi_req.arvalid && axi_rsp.arready) begin
      core_nxt.rvalid = 1'b1;
      core_nxt.rresp  = RESP_OKAY;
      core_nxt.rdata  = 32'h0;
      if (ra == A_CTRL) core_nxt.rdata[CTRL_GO] = !halted;
      else if (ra == A_STAT) core_nxt.rdata[3:0] =
        {core_r.bad_op, core_r.ext_err, core_r.st == S_SLEEP, core_r.st == S_HALT};
      else if (ra == A_PC) core_nxt.rdata = {8'h00, core_r.pc};
      else if (ra == A_FLAGS) core_nxt.rdata = {24'h0, core_r.flg};
      else if (ra[7:5] == ER_PAGE) core_nxt.rdata = core_r.er[ra[4:2]];
      else core_nxt.rresp = RESP_SLVERR;
    end

    // core sequencer; its flag sets come after software clears and win
    unique case (core_r.st)
      S_HALT, S_SLEEP: ;
      S_FETCH: if (mem_rsp.ready) begin
        core_nxt.ir = mem_rsp.rdata;
        core_nxt.pc = core_r.pc + INSN_BYTES;
        core_nxt.st = S_DECODE;
      end
      S_DECODE: begin
        core_nxt.ext_left = ext_need;
        core_nxt.st = (ext_need != 2'd0) ? S_EXT : S_EXEC;
      end
      S_EXT: if (mem_rsp.ready) begin
        core_nxt.ext = {core_r.ext[15:0], mem_rsp.rdata};
        core_nxt.pc = core_r.pc + INSN_BYTES;
        core_nxt.ext_left = core_r.ext_left - 2'd1;
        if (core_r.ext_left == 2'd1) core_nxt.st = S_EXEC;
      end
      S_EXEC: begin
        core_nxt.st = S_FETCH;
        unique case (op)
          OP_SYS: begin
            unique case (sub)
              SUB_IDLE: ;
              SUB_SLEEP: core_nxt.st = S_SLEEP;
              SUB_RTS, SUB_XRET: begin
                core_nxt.addr = core_r.er[SP_REG][15:0];
                core_nxt.st = S_RD_HI;
              end
              SUB_TRAP: begin
                core_nxt.hi = {core_r.flg, core_r.pc[23:16]};
                core_nxt.st = S_PUSH_HI;
              end
              SUB_MVB, SUB_MVW: if (cnt != 16'h0) core_nxt.st = S_MV_RD;
              default: begin
                core_nxt.bad_op = 1'b1;
                core_nxt.st = S_HALT;
              end
            endcase
          end
          OP_FLG_IMM: core_nxt.flg = core_r.ir[7:0];
          OP_FLG_AND: core_nxt.flg = core_r.flg & core_r.ir[7:0];
          OP_FLG_OR:  core_nxt.flg = core_r.flg | core_r.ir[7:0];
          OP_FLG_XOR: core_nxt.flg = core_r.flg ^ core_r.ir[7:0];
          OP_FLG_LDM, OP_FLG_STM: begin
            core_nxt.addr = core_r.er[core_r.ir[6:4]][15:0];
            core_nxt.st = (op == OP_FLG_LDM) ? S_LDM : S_STM;
          end
          OP_BCC8:  if (taken) core_nxt.pc = rel8;
          OP_BCC16: if (taken) core_nxt.pc = rel16;
          OP_GO_ABS: begin
            core_nxt.pc = core_r.ext[23:0];
            if (core_r.ext[31:24] != 8'h00) core_nxt.ext_err = 1'b1;
          end
          OP_GO_IND: core_nxt.pc = core_r.er[core_r.ir[6:4]][23:0];
          OP_CALL32, OP_CALL8, OP_CALL16: begin
            core_nxt.tgt = (op == OP_CALL32) ? core_r.ext[23:0] :
                           (op == OP_CALL8) ? rel8 : rel16;
            if (op == OP_CALL32 && core_r.ext[31:24] != 8'h00) core_nxt.ext_err = 1'b1;
            core_nxt.hi = {8'h00, core_r.pc[23:16]};
            core_nxt.st = S_PUSH_HI;
          end
          OP_FLG_LDR: core_nxt.flg = core_r.ir[3] ? core_r.er[core_r.ir[2:0]][7:0] :
                                                    core_r.er[core_r.ir[2:0]][15:8];
          OP_FLG_STR: core_nxt.er[core_r.ir[2:0]][7:0] = core_r.flg;
        endcase
      end
      S_LDM: if (mem_rsp.ready) begin
        core_nxt.flg = mem_rsp.rdata[15:8];
        core_nxt.st = S_FETCH;
      end
      S_STM: if (mem_rsp.ready) core_nxt.st = S_FETCH;
      S_PUSH_HI: if (mem_rsp.ready) core_nxt.st = S_PUSH_LO;
      S_PUSH_LO: if (mem_rsp.ready) begin
        core_nxt.er[SP_REG] = sp_m4;
        if (is_trap) begin
          core_nxt.addr = VEC_BASE + {12'h000, core_r.ir[1:0], 2'b00};
          core_nxt.st = S_RD_HI;
        end else begin
          core_nxt.pc = core_r.tgt;
          core_nxt.st = S_FETCH;
        end
      end
      S_RD_HI: if (mem_rsp.ready) begin
        core_nxt.hi = mem_rsp.rdata;
        core_nxt.st = S_RD_LO;
      end
      S_RD_LO: if (mem_rsp.ready) begin
        core_nxt.pc = {core_r.hi[7:0], mem_rsp.rdata};
        if (op == OP_SYS && sub == SUB_XRET) core_nxt.flg = core_r.hi[15:8];
        if (op == OP_SYS && (sub == SUB_RTS || sub == SUB_XRET))
          core_nxt.er[SP_REG] = core_r.er[SP_REG] + STACK_STEP;
        core_nxt.st = S_FETCH;
      end
      S_MV_RD: if (mem_rsp.ready) begin
        core_nxt.mv_byte = mem_rsp.rdata[7:0];
        core_nxt.st = S_MV_WR;
      end
      S_MV_WR: if (mem_rsp.ready) begin
        core_nxt.er[SRC_REG] = core_r.er[SRC_REG] + PTR_STEP;
        core_nxt.er[DST_REG] = core_r.er[DST_REG] + PTR_STEP;
        if (mvw) core_nxt.er[CNT_REG][15:0] = cnt - 16'h1;
        else core_nxt.er[CNT_REG][7:0] = cnt[7:0] - 8'h1;
        core_nxt.st = (cnt == 16'h1) ? S_FETCH : S_MV_RD;
      end
      default: core_nxt.st = S_HALT;
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_r     <= '0;
      core_r.flg <= FLAGS_RST;
      core_r.pc  <= PC_RST;
    end else begin
      core_r <= core_nxt;
    end
  end

endmodule : branch_sysctl_block_move_decode
`default_nettype wire

//--- test/mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module mem_model
  import branch_sysctl_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     slow,
  input  wire mem_req_t mem_req,
  output var  mem_rsp_t mem_rsp
);
  // ************************************************************
  // byte memory, big-endian words
  // ************************************************************
  logic [7:0]  bytes [0:65535];
  logic [1:0]  wait_r = 2'h0;
  logic [15:0] rd;
  // stale data is inverted so nothing passes by luck
  always_comb begin
    rd = mem_req.word ? {bytes[mem_req.addr], bytes[mem_req.addr + 16'h1]}
                      : {8'h00, bytes[mem_req.addr]};
    mem_rsp.ready = mem_req.valid && (wait_r == 2'h0);
    mem_rsp.rdata = mem_rsp.ready ? rd : ~rd;
  end
  // slow mode stalls each access for two cycles
  always @(posedge ref_clk) begin
    wait_r <= (mem_req.valid && wait_r != 2'h0) ? wait_r - 2'h1 : {slow, 1'b0};
    if (mem_rsp.ready && mem_req.write && mem_req.word) begin
      bytes[mem_req.addr] <= mem_req.wdata[15:8];
      bytes[mem_req.addr + 16'h1] <= mem_req.wdata[7:0];
    end else if (mem_rsp.ready && mem_req.write) begin
      bytes[mem_req.addr] <= mem_req.wdata[7:0];
    end
  end
endmodule : mem_model
`default_nettype wire

//--- test/branch_sysctl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module branch_sysctl_checker
  import branch_sysctl_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      arst_n,
  input wire axil_req_t axi_req,
  input wire axil_rsp_t axi_rsp,
  input wire mem_req_t  mem_req,
  input wire mem_rsp_t  mem_rsp,
  input wire logic      power_down
);
  // ************************************************************
  // port timing checks
  // ************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence aw_w_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence ar_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  chk_b_answer: assert property (aw_w_taken |=>
    !axi_rsp.awready ##1 axi_rsp.bvalid && !axi_rsp.awready)
    else $error("write answer missing");
  chk_r_answer: assert property (ar_taken |=> axi_rsp.rvalid) else $error("read answer late");
  chk_r_stands: assert property (axi_rsp.rvalid && !axi_req.rready |=> $stable(axi_rsp.rdata))
    else $error("read data moved");
  chk_ar_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready) else $error("ar open");
  chk_unmapped_read: assert property (ar_taken ##0 axi_req.araddr == 8'hFC |=>
    axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0) else $error("unmapped read ok");
  chk_word_even: assert property (mem_req.valid && mem_req.word |-> !mem_req.addr[0])
    else $error("odd word access");
  chk_req_holds: assert property (mem_req.valid && !mem_rsp.ready |=> $stable(mem_req))
    else $error("request moved");
  chk_sleep_quiet: assert property (power_down |-> !mem_req.valid)
    else $error("fetch in sleep");
endmodule : branch_sysctl_checker
bind branch_sysctl_block_move_decode branch_sysctl_checker chk_i (.ref_clk(ref_clk),
  .arst_n(arst_n), .axi_req(axi_req), .axi_rsp(axi_rsp), .mem_req(mem_req),
  .mem_rsp(mem_rsp), .power_down(power_down));
`default_nettype wire

//--- test/branch_sysctl_block_move_decode_tb.sv
`timescale 1ns/10ps
`default_nettype none
module branch_sysctl_block_move_decode_tb
  import branch_sysctl_pkg::*;
;
  logic ref_clk = 1'b0, arst_n = 1'b0, slow = 1'b0, power_down;
  axil_req_t axi_req = '0;
  axil_rsp_t axi_rsp;
  mem_req_t mem_req;
  mem_rsp_t mem_rsp;
  int fails = 0, check_count = 0, n;
  logic [1:0] resp;
  logic [31:0] d, e4;
  logic [7:0] f, a, o, x;
  branch_sysctl_block_move_decode dut (.ref_clk(ref_clk), .arst_n(arst_n), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .mem_req(mem_req), .mem_rsp(mem_rsp), .power_down(power_down));
  mem_model mem (.ref_clk(ref_clk), .slow(slow), .mem_req(mem_req), .mem_rsp(mem_rsp));
  // ************************************************************
  // helpers
  // ************************************************************
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic put(input logic [15:0] adr, input logic [15:0] w);
    mem.bytes[adr] = w[15:8];
    mem.bytes[adr + 16'h1] = w[7:0];
  endtask : put
  task automatic axw(input logic [7:0] adr, input logic [31:0] w);
    @(posedge ref_clk);
    {axi_req.awaddr, axi_req.wdata, axi_req.wstrb} <= {adr, w, 4'hF};
    {axi_req.awvalid, axi_req.wvalid, axi_req.bready} <= 3'b111;
    for (int i = 0; i < 99; i++) begin
      @(posedge ref_clk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) break;
    end
    if (!axi_rsp.bvalid) fails++;
    resp = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask : axw
  // ready waits for valid so the answer is seen standing
  task automatic axr(input logic [7:0] adr, output logic [31:0] r);
    @(posedge ref_clk);
    {axi_req.araddr, axi_req.arvalid} <= {adr, 1'b1};
    for (int i = 0; i < 99; i++) begin
      @(posedge ref_clk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid && axi_req.rready) break;
      if (axi_rsp.rvalid) axi_req.rready <= 1'b1;
    end
    if (!(axi_rsp.rvalid && axi_req.rready)) fails++;
    {r, resp} = {axi_rsp.rdata, axi_rsp.rresp};
    axi_req.rready <= 1'b0;
  endtask : axr
  task automatic run();
    slow <= 1'($urandom);
    axw(A_PC, 32'h0);
    axw(A_CTRL, 32'h1);
    for (int i = 0; i < 200; i++) begin
      axr(A_STAT, d);
      if (d[STAT_HALT] === 1'b1 || d[STAT_SLEEP] === 1'b1) break;
    end
    if (d[STAT_HALT] !== 1'b1 && d[STAT_SLEEP] !== 1'b1) fails++;
  endtask : run
  // flag bits: c 0, v 1, z 2, n 3; even codes test, odd invert
  function automatic logic taken(input logic [3:0] cc, input logic [3:0] fl);
    logic [7:0] t;
    t = {~(fl[3] ^ fl[1] | fl[2]), ~(fl[3] ^ fl[1]), ~fl[3], ~fl[1], ~fl[2], ~fl[0],
         ~(fl[0] | fl[2]), 1'b1};
    return t[cc[3:1]] ^ cc[0];
  endfunction : taken
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (80000) @(posedge ref_clk);
    fails++;
    give_verdict();
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    void'($urandom(38222));
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // every condition against every flag pattern, flags loaded just before
    for (int cc = 0; cc < 16; cc++) for (int nb = 0; nb < 16; nb++) begin
      f = {4'h8, 4'(nb)};
      put(0, {8'h10, f}); put(2, {4'h7, 4'(cc), 8'h04}); put(4, 16'h1055);
      put(6, 16'h0F00); put(8, 16'h0F00);
      run(); axr(A_FLAGS, d);
      chk(d, taken(4'(cc), 4'(nb)) ? f : 8'h55);
    end
    // flag logic, block move of 0..3 bytes, call and return
    for (int i = 0; i < 8; i++) begin
      n = i % 4; {a, o, x, f} = $urandom;
      e4 = (i < 4) ? 32'h0012AB00 | n : 32'h00120000 | n;
      for (int k = 0; k < 4; k++) {mem.bytes[256 + k], mem.bytes[512 + k]} = {8'($urandom), 8'hEE};
      put(0, {8'h20, a}); put(2, {8'h30, o}); put(4, {8'h40, x}); put(6, 16'h0000);
      put(8, (i < 4) ? 16'h0500 : 16'h0600); put(10, 16'hB002); put(12, 16'h0F00); put(14, 16'h0200);
      axw(A_FLAGS, f); axw(8'h30, e4); axw(8'h34, 32'h100); axw(8'h38, 32'h200); axw(8'h3C, 32'h1000);
      run();
      axr(A_FLAGS, d); chk(d, ((f & a) | o) ^ x);
      axr(8'h30, d); chk(d, e4 & ~32'h3);
      axr(8'h34, d); chk(d, 32'h100 + n);
      axr(8'h38, d); chk(d, 32'h200 + n);
      for (int k = 0; k < 4; k++) chk(mem.bytes[512 + k], k < n ? mem.bytes[256 + k] : 8'hEE);
      axr(8'h3C, d); chk(d, 32'h1000);
      chk({mem.bytes[16'hFFE], mem.bytes[16'hFFF]}, 16'h000C);
    end
    // trap, exception return, jump, call, flag stores
    a = 8'($urandom);
    put(0, 16'h9000); put(2, 16'h0); put(4, 16'h0010); put(16, 16'h0402); put(18, 16'hA000);
    put(20, 16'h0); put(22, 16'h0050); put(24, 16'h0F00); put(40, 16'h0); put(42, 16'h0040);
    put(64, 16'h1000); put(66, 16'h0300); put(80, 16'h6030); put(82, 16'hF002); put(84, 16'h0200);
    axw(A_FLAGS, a); axw(8'h2C, 32'h300); run();
    axr(A_FLAGS, d); chk(d, a);
    axr(8'h28, d); chk(d[7:0], a);
    chk({mem.bytes[768], mem.bytes[769]}, {a, 8'h00});
    chk({mem.bytes[16'hFFE], mem.bytes[16'hFFF]}, 16'h0018);
    axr(8'hFC, d); chk(d, 32'h0); chk(resp, RESP_SLVERR);
    put(0, 16'h0100); run();
    chk(power_down, 1'b1);
    give_verdict();
  end
endmodule : branch_sysctl_block_move_decode_tb
`default_nettype wire
